// ---- verilog/tpsc_pkg.sv ----
// Package with register map, field positions, reset values and carrier types of the touch status block.
`default_nettype none
package tpsc_pkg;
  localparam int unsigned NCH = 8;
  // Register offsets.
  localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GENERAL_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CHANNEL_TOUCH_STATUS = 8'h03;
  localparam logic [7:0] ADDR_LED_DONE_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL_NOISE_STATUS = 8'h0a;
  // Main control fields.
  localparam int unsigned MC_GAIN_LSB = 6;
  localparam int unsigned MC_LOW_POWER_SCAN_BIT = 5;
  localparam int unsigned MC_DEEP_IDLE_BIT = 4;
  localparam int unsigned MC_INT_BIT = 0;
  // General status fields.
  localparam int unsigned GS_LED_BIT = 4;
  localparam int unsigned GS_RESET_BIT = 3;
  localparam int unsigned GS_MANY_TOUCH_BIT = 2;
  localparam int unsigned GS_PATTERN_BIT = 1;
  localparam int unsigned GS_TOUCH_BIT = 0;
  // Reset values and the pattern count width.
  localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [1:0] RST_GAIN = 2'h0;
  localparam logic [3:0] PATTERN_COUNT_WIDTH = 4'h4;

  // One register access from the serial front end, same clock domain.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpsc_reg_req_type;

  // Per-channel results of the sensing engine for the current cycle.
  typedef struct packed {
    logic [NCH-1:0] touch;
    logic [NCH-1:0] int_en;
    logic [NCH-1:0] noise_low_freq;
    logic [NCH-1:0] noise_rf;
    logic [NCH-1:0] pattern_delta_over;
  } tpsc_sense_type;

  // Global configuration bits that live in registers outside this block.
  typedef struct packed {
    logic pattern_detect_enable;
    logic pattern_irq_enable;
    logic keep_low_freq_noisy_samples;
    logic keep_rf_noisy_samples;
    logic wake_on_touch;
    logic four_wire_link;
  } tpsc_cfg_type;
endpackage : tpsc_pkg
`default_nettype wire

// ---- verilog/tpsc_top.sv ----
// Control and status register logic of the eight-channel touch controller.
`timescale 1ns/1ps
`default_nettype none
module tpsc_top
  import tpsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire tpsc_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire tpsc_sense_type sense,
  input wire tpsc_cfg_type cfg,
  input wire logic [NCH-1:0] standby_select,
  input wire logic [NCH-1:0][7:0] delta_raw,
  input wire logic [NCH-1:0] led_done_evt,
  input wire logic [NCH-1:0] led_linked,
  input wire logic many_touch_block,
  input wire logic pattern_condition,
  input wire logic reset_pin_released,
  input wire logic wake_in,
  output logic wake_out,
  output logic wake_oe_n,
  output logic alert_n,
  output logic [1:0] gain_code,
  output logic [3:0] gain_factor,
  output logic [NCH-1:0] scan_enable,
  output logic [NCH-1:0] channel_release,
  output logic leds_force_inactive,
  output logic pwm_enable,
  output logic [NCH-1:0][7:0] delta_out,
  output logic [NCH-1:0] sample_discard,
  output logic [3:0] pattern_count
);

  // Gain code to multiplier: 00, 01, 10, 11 give 1, 2, 4, 8.
  function automatic logic [3:0] gain_decode(input logic [1:0] code);
    gain_decode = 4'h1 << code;
  endfunction : gain_decode

  // Number of set bits in a channel vector.
  function automatic logic [3:0] ones_count(input logic [NCH-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NCH; i++) begin
      n = n + {3'h0, v[i]};
    end
    ones_count = n;
  endfunction : ones_count

  // Registers.
  logic [1:0] gain_q;
  logic low_power_scan_enable_q;
  logic deep_idle_enable_q;
  logic int_q;
  logic [NCH-1:0] touch_status_q;
  logic [NCH-1:0] led_done_q;
  logic [NCH-1:0] noise_q;
  logic reset_seen_q;
  logic pattern_touch_flag_q;
  logic many_touch_block_flag_q;
  logic wake_q;
  logic por_q;
  logic [NCH-1:0] touch_prev_q;
  logic [NCH-1:0] scan_prev_q;
  logic [NCH-1:0] release_q;
  logic wake_meta_q;
  logic wake_sync_q;
  logic [NCH-1:0][7:0] delta_q;
  logic [NCH-1:0] discard_q;
  logic [3:0] pattern_count_q;
  logic [7:0] rdata_q;

  // Register decode; anything not matched here is unassigned.
  wire hit_main = reg_req.addr == ADDR_MAIN_CONTROL;
  wire hit_gen = reg_req.addr == ADDR_GENERAL_STATUS;
  wire hit_touch = reg_req.addr == ADDR_CHANNEL_TOUCH_STATUS;
  wire hit_led = reg_req.addr == ADDR_LED_DONE_STATUS;
  wire hit_noise = reg_req.addr == ADDR_CHANNEL_NOISE_STATUS;
  wire wr_main = reg_req.wr & hit_main;
  wire int_clr = wr_main & ~reg_req.wdata[MC_INT_BIT];
  wire int_wr_set = wr_main & reg_req.wdata[MC_INT_BIT];
  wire deep_enter = wr_main & reg_req.wdata[MC_DEEP_IDLE_BIT] & ~deep_idle_enable_q;

  // The wake pin only counts as a wake request while we are not driving it ourselves.
  wire wake_hit = wake_sync_q & wake_oe_n;

  // Scanning: nothing in deep idle, the selected subset in low-power scan, else all.
  wire [NCH-1:0] scan_d = deep_idle_enable_q ? '0 :
    (low_power_scan_enable_q ? standby_select : '1);

  // Noise flags follow the analog report with no latch.
  wire [NCH-1:0] noise_now = sense.noise_low_freq | sense.noise_rf;
  wire [NCH-1:0] discard_d = (sense.noise_low_freq & {NCH{~cfg.keep_low_freq_noisy_samples}}) |
    (sense.noise_rf & {NCH{~cfg.keep_rf_noisy_samples}});

  // A noisy channel raises no new touch because noise masks its touch bit directly.
  wire [NCH-1:0] touch_eff = sense.touch & scan_d & ~noise_now;
  wire [NCH-1:0] new_touch = touch_eff & ~touch_prev_q;
  wire touch_irq = |(new_touch & sense.int_en);

  // Pattern: noisy or over-threshold channels, each counted once.
  wire [NCH-1:0] pattern_over = (noise_now | sense.pattern_delta_over) &
    {NCH{cfg.pattern_detect_enable}};
  wire pattern_rise = pattern_condition & ~pattern_touch_flag_q;
  wire pattern_irq = pattern_rise & cfg.pattern_irq_enable;

  wire led_set_any = |(led_done_evt & ~led_linked);
  wire reset_evt = por_q | reset_pin_released;
  wire int_set = touch_irq | pattern_irq | reset_evt | int_wr_set;
  wire standby_touch = low_power_scan_enable_q & ~deep_idle_enable_q & cfg.wake_on_touch & (|new_touch);

  // Next values of the sticky flags; a new event wins over a flag clear in the same cycle, deep idle entry wins over both.
  wire int_d = deep_enter ? 1'b0 : (int_set ? 1'b1 : (int_clr ? 1'b0 : int_q));
  wire [NCH-1:0] touch_status_d = deep_enter ? '0 :
    (new_touch | (touch_status_q & ~({NCH{int_clr}} & ~touch_eff)));
  wire [NCH-1:0] led_done_d = deep_enter ? '0 :
    ((led_done_evt & ~led_linked) | (led_done_q & ~{NCH{int_clr}}));
  wire reset_seen_d = deep_enter ? 1'b0 : (reset_evt | (reset_seen_q & ~int_clr));
  wire wake_d = deep_enter ? 1'b0 : (standby_touch | (wake_q & ~int_clr));

  // General status read value with live summary bits.
  wire [7:0] gen_status = {3'h0, |led_done_q, reset_seen_q, many_touch_block_flag_q,
    pattern_touch_flag_q, |touch_status_q};
  wire [7:0] main_rd = {gain_q, low_power_scan_enable_q, deep_idle_enable_q, 3'h0, int_q};
  wire [7:0] rd_mux = hit_main ? main_rd :
    hit_gen ? gen_status :
    hit_touch ? touch_status_q :
    hit_led ? led_done_q :
    hit_noise ? noise_q : RST_STATUS;

  // Wake pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_in;
      wake_sync_q <= wake_meta_q;
    end
  end

  // Main control register; the wake pin beats a host write on the deep idle bit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gain_q <= RST_GAIN;
      low_power_scan_enable_q <= RST_MAIN_CONTROL[MC_LOW_POWER_SCAN_BIT];
      deep_idle_enable_q <= RST_MAIN_CONTROL[MC_DEEP_IDLE_BIT];
    end else begin
      if (wr_main) begin
        gain_q <= reg_req.wdata[MC_GAIN_LSB +: 2];
        low_power_scan_enable_q <= reg_req.wdata[MC_LOW_POWER_SCAN_BIT];
      end
      if (wake_hit) begin
        deep_idle_enable_q <= 1'b0;
      end else if (wr_main) begin
        deep_idle_enable_q <= reg_req.wdata[MC_DEEP_IDLE_BIT];
      end
    end
  end

  // Interrupt flag and sticky status bits.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_q <= RST_MAIN_CONTROL[MC_INT_BIT];
      touch_status_q <= RST_STATUS;
      led_done_q <= RST_STATUS;
      reset_seen_q <= 1'b0;
      wake_q <= 1'b0;
      por_q <= 1'b1;
    end else begin
      int_q <= int_d;
      touch_status_q <= touch_status_d;
      led_done_q <= led_done_d;
      reset_seen_q <= reset_seen_d;
      wake_q <= wake_d;
      por_q <= 1'b0;
    end
  end

  // Level flags that follow their causes; deep idle entry empties them.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      noise_q <= RST_STATUS;
      pattern_touch_flag_q <= 1'b0;
      many_touch_block_flag_q <= 1'b0;
    end else begin
      noise_q <= deep_enter ? '0 : noise_now;
      pattern_touch_flag_q <= ~deep_enter & pattern_condition;
      many_touch_block_flag_q <= ~deep_enter & many_touch_block;
    end
  end

  // Channel tracking: release pulse when any channel leaves the scan set.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      touch_prev_q <= '0;
      scan_prev_q <= '0;
      release_q <= '0;
    end else begin
      touch_prev_q <= touch_eff;
      scan_prev_q <= scan_d;
      release_q <= scan_prev_q & ~scan_d;
    end
  end

  // Sample path outputs; noise zeroes the delta before anyone compares it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      delta_q <= '0;
      discard_q <= '0;
      pattern_count_q <= 4'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        delta_q[i] <= noise_now[i] ? 8'h00 : delta_raw[i];
      end
      discard_q <= discard_d;
      pattern_count_q <= ones_count(pattern_over);
    end
  end

  // Read data register; reads carry no side effects.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= RST_STATUS;
    end else if (reg_req.rd) begin
      rdata_q <= rd_mux;
    end
  end

  // Output drive. The wake pin is released in four-wire mode because it carries link data.
  assign reg_rdata = rdata_q;
  assign alert_n = ~int_q;
  assign wake_out = 1'b1;
  assign wake_oe_n = ~(wake_q & ~cfg.four_wire_link);
  assign gain_code = gain_q;
  assign gain_factor = gain_decode(gain_q);
  assign scan_enable = scan_prev_q;
  assign channel_release = release_q;
  assign leds_force_inactive = deep_idle_enable_q;
  assign pwm_enable = ~deep_idle_enable_q;
  assign delta_out = delta_q;
  assign sample_discard = discard_q;
  assign pattern_count = pattern_count_q;

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_clear_write;
    wr_main && !reg_req.wdata[MC_INT_BIT];
  endsequence
  sequence s_quiet;
    !int_set && !deep_enter;
  endsequence

  a_gain_decode: assert property (gain_factor == (4'h1 << gain_code))
    else $error("gain factor does not match gain code");
  a_deep_scan_off: assert property (deep_idle_enable_q |=> scan_enable == '0)
    else $error("scanning while in deep idle");
  a_wake_clears: assert property ((wake_hit && deep_idle_enable_q) |=> !deep_idle_enable_q)
    else $error("wake pin did not clear deep idle");
  a_deep_clears: assert property (deep_enter |=> !int_q && touch_status_q == '0 && led_done_q == '0)
    else $error("deep idle entry left status set");
  a_alert_follows: assert property (alert_n == !int_q)
    else $error("alert does not follow interrupt flag");
  a_no_irq_masked: assert property ((!int_q && !int_wr_set && !reset_evt && !pattern_irq
    && (new_touch & sense.int_en) == '0) |=> !int_q)
    else $error("interrupt without enabled cause");
  a_clear_int: assert property ((s_clear_write ##0 s_quiet) |=> !int_q ##0 alert_n)
    else $error("interrupt clear not honoured");
  a_wake_drop: assert property ((s_clear_write ##0 !standby_touch) |=> wake_oe_n)
    else $error("wake still driven after clear");
  a_four_wire: assert property (cfg.four_wire_link |-> wake_oe_n)
    else $error("wake driven in four-wire mode");
  a_touch_hold: assert property ((touch_status_q[0] && touch_eff[0] && !deep_enter) |=> touch_status_q[0])
    else $error("touch bit dropped while touch held");
  a_noise_follow: assert property (noise_now[0] && !deep_enter |=> noise_q[0] && delta_out[0] == 8'h00)
    else $error("noise flag or delta zeroing wrong");
  a_reset_seen: assert property ($rose(reset_seen_q) |-> int_q)
    else $error("reset-seen without interrupt");

endmodule : tpsc_top
`default_nettype wire

// ---- test/tpsc_host_model.sv ----
// Host controller model that issues register accesses to the touch status block.
`timescale 1ns/1ps
`default_nettype none
module tpsc_host_model
  import tpsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output var tpsc_reg_req_type reg_req
);
  // The bus idles with no strobe so nothing is taken before the first access.
  initial reg_req = '0;

  // One write cycle; a zero in bit 0 of main control is how the host drops the flag.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    reg_req <= '0;
  endtask : reg_write

  // One read cycle; data is registered, so it is settled one edge after the strobe.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    reg_req <= '0;
    d = reg_rdata;
  endtask : reg_read
endmodule : tpsc_host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking testbench of the touch status register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tpsc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  tpsc_reg_req_type reg_req;
  tpsc_sense_type sense = '0;
  tpsc_cfg_type cfg = '0;
  logic [7:0] reg_rdata, standby_select = 8'hff, led_done_evt = 8'h00, led_linked = 8'h00;
  logic [NCH-1:0][7:0] delta_raw = '0, delta_out;
  logic many_touch_block = 1'b0, pattern_condition = 1'b0, reset_pin_released = 1'b0, wake_in = 1'b0;
  logic wake_out, wake_oe_n, alert_n, leds_force_inactive, pwm_enable;
  logic [1:0] gain_code;
  logic [3:0] gain_factor, pattern_count;
  logic [7:0] scan_enable, channel_release, sample_discard;
  int miscompares = 0;
  int num_checks = 0;

  // Half period of 2.5 ns gives the 200 MHz core clock.
  always #2.5 core_clk = ~core_clk;

  tpsc_host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
  tpsc_top DUT (.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .sense(sense),
    .cfg(cfg), .standby_select(standby_select), .delta_raw(delta_raw), .led_done_evt(led_done_evt),
    .led_linked(led_linked), .many_touch_block(many_touch_block), .pattern_condition(pattern_condition),
    .reset_pin_released(reset_pin_released), .wake_in(wake_in), .wake_out(wake_out), .wake_oe_n(wake_oe_n),
    .alert_n(alert_n), .gain_code(gain_code), .gain_factor(gain_factor), .scan_enable(scan_enable),
    .channel_release(channel_release), .leds_force_inactive(leds_force_inactive), .pwm_enable(pwm_enable),
    .delta_out(delta_out), .sample_discard(sample_discard), .pattern_count(pattern_count));

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.reg_read(a, d);
    chk(n, d, e);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  // Reset values, then the reset-seen flag and its interrupt dropped by the host.
  task automatic t_reset();
    idle(3);
    rchk("main", ADDR_MAIN_CONTROL, 8'h01);
    rchk("gstat", ADDR_GENERAL_STATUS, 8'h08);
    rchk("touch", ADDR_CHANNEL_TOUCH_STATUS, 8'h00);
    rchk("led", ADDR_LED_DONE_STATUS, 8'h00);
    rchk("noise", ADDR_CHANNEL_NOISE_STATUS, 8'h00);
    chk("alert", {7'h0, alert_n}, 8'h00);
    host.reg_write(ADDR_MAIN_CONTROL, 8'h00);
    chk("alert", {7'h0, alert_n}, 8'h01);
    rchk("gstat", ADDR_GENERAL_STATUS, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // Every gain code and its factor.
  task automatic t_gain();
    for (int i = 0; i < 4; i++) begin
      host.reg_write(ADDR_MAIN_CONTROL, {i[1:0], 6'h00});
      chk("gain", {4'h0, gain_factor}, 8'h01 << i);
      chk("code", {6'h0, gain_code}, {6'h0, i[1:0]});
    end
    host.reg_write(ADDR_MAIN_CONTROL, 8'h00);
    $display("test gain done");
  endtask : t_gain

  // Touch with and without interrupt enable, held through a flag clear.
  task automatic t_touch();
    sense.touch[0] = 1'b1;
    sense.int_en[0] = 1'b1;
    idle(2);
    chk("alert", {7'h0, alert_n}, 8'h00);
    rchk("touch", ADDR_CHANNEL_TOUCH_STATUS, 8'h01);
    rchk("gstat", ADDR_GENERAL_STATUS, 8'h01);
    host.reg_write(ADDR_MAIN_CONTROL, 8'h00);
    chk("alert", {7'h0, alert_n}, 8'h01);
    rchk("touch", ADDR_CHANNEL_TOUCH_STATUS, 8'h01);
    idle(3);
    chk("alert", {7'h0, alert_n}, 8'h01);
    sense.touch = 8'h02;
    idle(3);
    chk("alert", {7'h0, alert_n}, 8'h01);
    sense.touch = 8'h00;
    host.reg_write(ADDR_MAIN_CONTROL, 8'h00);
    rchk("touch", ADDR_CHANNEL_TOUCH_STATUS, 8'h00);
    $display("test touch done");
  endtask : t_touch

  // Noise flags, delta zeroing, the low-frequency discard keep bit and the pattern count.
  task automatic t_noise();
    delta_raw[2] = 8'h33;
    delta_raw[3] = 8'h21;
    cfg.pattern_detect_enable = 1'b1;
    sense.pattern_delta_over = 8'h24;
    sense.noise_low_freq = 8'h0c;
    idle(2);
    rchk("noise", ADDR_CHANNEL_NOISE_STATUS, 8'h0c);
    chk("delta2", delta_out[2], 8'h00);
    chk("pcount", {4'h0, pattern_count}, 8'h03);
    chk("disc", sample_discard, 8'h0c);
    cfg.keep_low_freq_noisy_samples = 1'b1;
    sense.noise_rf = 8'h08;
    idle(2);
    chk("disc", sample_discard, 8'h08);
    sense.noise_low_freq = 8'h00;
    sense.noise_rf = 8'h00;
    idle(2);
    rchk("noise", ADDR_CHANNEL_NOISE_STATUS, 8'h00);
    chk("delta3", delta_out[3], 8'h21);
    $display("test noise done");
  endtask : t_noise

  // LED completion, linked LED ignored, and clear with the flag.
  task automatic t_led();
    led_linked = 8'h20;
    led_done_evt = 8'h28;
    idle(1);
    led_done_evt = 8'h00;
    idle(1);
    rchk("led", ADDR_LED_DONE_STATUS, 8'h08);
    rchk("gstat", ADDR_GENERAL_STATUS, 8'h10);
    host.reg_write(ADDR_MAIN_CONTROL, 8'h00);
    rchk("led", ADDR_LED_DONE_STATUS, 8'h00);
    $display("test led done");
  endtask : t_led

  // Unassigned places and read-only status.
  task automatic t_map();
    host.reg_write(8'h05, 8'hff);
    rchk("unmap", 8'h05, 8'h00);
    host.reg_write(ADDR_CHANNEL_TOUCH_STATUS, 8'hff);
    rchk("ro", ADDR_CHANNEL_TOUCH_STATUS, 8'h00);
    reset_pin_released = 1'b1;
    idle(1);
    reset_pin_released = 1'b0;
    idle(1);
    chk("alert", {7'h0, alert_n}, 8'h00);
    rchk("gstat", ADDR_GENERAL_STATUS, 8'h08);
    host.reg_write(ADDR_MAIN_CONTROL, 8'h00);
    rchk("gstat", ADDR_GENERAL_STATUS, 8'h00);
    $display("test map done");
  endtask : t_map

  // Deep idle entry clears status, then the wake pin leaves it.
  task automatic t_sleep();
    int i;
    sense.touch = 8'h01;
    idle(2);
    sense.touch = 8'h00;
    host.reg_write(ADDR_MAIN_CONTROL, 8'h10);
    rchk("touch", ADDR_CHANNEL_TOUCH_STATUS, 8'h00);
    chk("alert", {7'h0, alert_n}, 8'h01);
    chk("park", {6'h0, leds_force_inactive, pwm_enable}, 8'h02);
    chk("scan", scan_enable, 8'h00);
    wake_in = 1'b1;
    #32 wake_in = 1'b0;
    for (i = 0; i < 12 && leds_force_inactive !== 1'b0; i++) idle(1);
    if (i == 12) begin
      chk("wake timeout", 8'h01, 8'h00);
      end_of_test();
    end
    rchk("main", ADDR_MAIN_CONTROL, 8'h00);
    $display("test sleep done");
  endtask : t_sleep

  // Low-power scan wake output, released on flag clear and never driven in four-wire mode.
  task automatic t_wake();
    cfg.wake_on_touch = 1'b1;
    standby_select = 8'h01;
    host.reg_write(ADDR_MAIN_CONTROL, 8'h20);
    idle(1);
    chk("release", channel_release, 8'hfe);
    idle(1);
    chk("scan", scan_enable, 8'h01);
    sense.touch = 8'h01;
    idle(3);
    chk("wake", {7'h0, wake_oe_n}, 8'h00);
    chk("wakeo", {7'h0, wake_out}, 8'h01);
    host.reg_write(ADDR_MAIN_CONTROL, 8'h20);
    chk("wake", {7'h0, wake_oe_n}, 8'h01);
    sense.touch = 8'h00;
    cfg.four_wire_link = 1'b1;
    idle(2);
    sense.touch = 8'h01;
    idle(3);
    chk("wake4", {7'h0, wake_oe_n}, 8'h01);
    $display("test wake done");
  endtask : t_wake

  // Reset is held for three cycles, then the scenarios run in turn.
  initial begin
    idle(3);
    rst = 1'b0;
    t_reset();
    t_gain();
    t_touch();
    t_noise();
    t_led();
    t_map();
    t_sleep();
    t_wake();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
